// file: rtl/nvm_pkg.sv
// Purpose: Shared constants and types for the byte EEPROM controller and its CPU-side end.
// Assumes: pclk at 200 MHz; one 8-bit register port between the two ends.
// Notes: Program times are in microseconds and become oscillator ticks in the device.
package nvm_pkg;
	// ----------------------------------------------------------------
	// Storage and register port
	// ----------------------------------------------------------------
	localparam int ADDR_W = 6;
	localparam int MEM_DEPTH = 64;
	localparam int DATA_W = 8;
	localparam logic [DATA_W-1:0] ERASED_BYTE = 8'hff;
	localparam logic [1:0] SEL_ADDR = 2'h0;
	localparam logic [1:0] SEL_DATA = 2'h1;
	localparam logic [1:0] SEL_CTRL = 2'h2;
	localparam int CTRL_READ = 0;
	localparam int CTRL_GO = 1;
	localparam int CTRL_ARM = 2;
	localparam int CTRL_MODE = 4;
	localparam logic [1:0] MODE_ATOMIC = 2'h0;
	localparam logic [1:0] MODE_ERASE = 2'h1;
	localparam logic [1:0] MODE_WRITE = 2'h2;
	localparam logic [1:0] MODE_RSVD = 2'h3;
	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam logic [2:0] ARM_WINDOW = 3'h4;
	localparam logic [2:0] READ_STALL = 3'h4;
	localparam logic [2:0] PROG_STALL = 3'h2;
	localparam int CLK_PERIOD_NS = 5;
	localparam int OSC_TICK_NS = 1000;
	localparam int OSC_DIV = OSC_TICK_NS / CLK_PERIOD_NS;
	localparam int NS_PER_US = 1000;
	localparam int ATOMIC_TIME_US = 3400;
	localparam int SPLIT_TIME_US = 1800;
	localparam int TICK_W = 12;
	// ----------------------------------------------------------------
	// APB map of the controller
	// ----------------------------------------------------------------
	localparam int APB_AW = 12;
	localparam int APB_DW = 32;
	localparam logic [APB_AW-1:0] OFF_ADDR = 12'h000;
	localparam logic [APB_AW-1:0] OFF_DATA = 12'h004;
	localparam logic [APB_AW-1:0] OFF_CTRL = 12'h008;
	localparam logic [APB_AW-1:0] OFF_CMD = 12'h00c;
	localparam logic [APB_AW-1:0] OFF_STATUS = 12'h010;
	localparam logic [APB_AW-1:0] OFF_MASK = 12'h014;
	localparam int CMD_START = 0;
	localparam int CMD_READ = 1;
	localparam int CMD_MODE = 4;
	localparam int ST_DONE = 0;
	localparam int ST_REFUSED = 1;
	localparam int ST_W = 2;

	typedef enum logic [1:0] {DEV_IDLE = 2'b01, DEV_PROG = 2'b10} dev_state_t;
	typedef enum logic [2:0] {H_IDLE = 3'b001, H_GO = 3'b010, H_WAIT = 3'b100} host_state_t;
endpackage

// file: rtl/nvm_if.sv
// Purpose: Register port between the CPU-side controller and the EEPROM device.
// Assumes: Both ends on pclk; requests are one-cycle pulses.
// Notes: stall and busy are levels from device flip-flops.
`timescale 1ns/1ps
interface nvm_if;
	logic [1:0] reg_sel;
	logic reg_wr;
	logic reg_rd;
	logic [nvm_pkg::DATA_W-1:0] reg_wdata;
	logic [nvm_pkg::DATA_W-1:0] reg_rdata;
	logic stall;
	logic busy;
	modport device(input reg_sel, input reg_wr, input reg_rd, input reg_wdata,
		output reg_rdata, output stall, output busy);
	modport controller(output reg_sel, output reg_wr, output reg_rd, output reg_wdata,
		input reg_rdata, input stall, input busy);
endinterface

// file: rtl/osc_tick_div.sv
// Purpose: Stands in for the calibrated oscillator as a one-cycle tick enable.
// Assumes: DIV of at least one.
// Notes: Restarts from zero whenever run falls, so each operation starts aligned.
`timescale 1ns/1ps
module osc_tick_div #(
	parameter int unsigned DIV = nvm_pkg::OSC_DIV
) (
	input wire logic pclk,
	input wire logic rst_n,
	input wire logic run,
	output logic tick
);
	import nvm_pkg::*;

	logic [15:0] cnt;

	always_ff @(posedge pclk or negedge rst_n) begin
		if (!rst_n) begin
			cnt <= '0;
		end else if (!run || tick) begin
			cnt <= '0;
		end else begin
			cnt <= cnt + 16'h0001;
		end
	end

	assign tick = run && (cnt == 16'(DIV - 1));
endmodule

// file: rtl/nvm_byte_device.sv
// Purpose: Byte-wide 64-location EEPROM with armed program strobe and CPU stall.
// Assumes: The controller issues no new access while stall is high.
// Notes: por_n resets the engine; presetn resets only the CPU-facing registers.
//
// Decided for this implementation: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ps
module nvm_byte_device #(
	parameter int unsigned PROG_ATOMIC_US = nvm_pkg::ATOMIC_TIME_US,
	parameter int unsigned PROG_SPLIT_US = nvm_pkg::SPLIT_TIME_US,
	parameter int unsigned OSC_TICK_CYCLES = nvm_pkg::OSC_DIV
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic por_n,
	nvm_if.device bus
);
	import nvm_pkg::*;

	localparam logic [TICK_W-1:0] ATOMIC_TICKS =
		TICK_W'(PROG_ATOMIC_US * NS_PER_US / OSC_TICK_NS);
	localparam logic [TICK_W-1:0] SPLIT_TICKS =
		TICK_W'(PROG_SPLIT_US * NS_PER_US / OSC_TICK_NS);
	localparam logic [TICK_W-1:0] ONE_TICK = 12'h001;

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	logic [DATA_W-1:0] mem [MEM_DEPTH];
	logic [ADDR_W-1:0] nvm_byte_address_reg;
	logic [DATA_W-1:0] nvm_byte_data_reg;
	logic [1:0] program_mode_select;
	logic program_arm_bit;
	logic program_go_bit;
	logic [2:0] arm_age;
	logic [2:0] stall_cnt;
	dev_state_t state;
	logic [ADDR_W-1:0] op_addr;
	logic [DATA_W-1:0] op_data;
	logic [1:0] op_mode;
	logic [TICK_W-1:0] ticks_left;
	logic osc_tick;
	logic rst_meta;
	logic rst_seen;
	logic wr_ctrl;
	logic go_ok;
	logic read_ok;
	logic commit;

	function automatic logic [TICK_W-1:0] prog_ticks(input logic [1:0] mode);
		prog_ticks = (mode == MODE_ATOMIC) ? ATOMIC_TICKS : SPLIT_TICKS;
	endfunction

	function automatic logic [DATA_W-1:0] new_byte(input logic [1:0] mode,
		input logic [DATA_W-1:0] old, input logic [DATA_W-1:0] din);
		case (mode)
			MODE_ATOMIC: new_byte = din;
			MODE_ERASE: new_byte = ERASED_BYTE;
			// Write-only can only clear bits, so an unerased cell ends up corrupted.
			MODE_WRITE: new_byte = old & din;
			default: new_byte = old;
		endcase
	endfunction

	assign program_go_bit = (state == DEV_PROG);
	assign wr_ctrl = bus.reg_wr && (bus.reg_sel == SEL_CTRL);
	assign go_ok = wr_ctrl && bus.reg_wdata[CTRL_GO] && program_arm_bit
		&& !program_go_bit && (program_mode_select != MODE_RSVD);
	assign read_ok = wr_ctrl && bus.reg_wdata[CTRL_READ] && !program_go_bit;
	assign commit = program_go_bit && osc_tick && (ticks_left == ONE_TICK);
	assign bus.busy = program_go_bit;
	assign bus.stall = (stall_cnt != 3'h0);

	// ----------------------------------------------------------------
	// CPU reset seen in the pclk domain
	// ----------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rst_meta <= 1'b1;
			rst_seen <= 1'b1;
		end else begin
			rst_meta <= 1'b0;
			rst_seen <= rst_meta;
		end
	end

	// ----------------------------------------------------------------
	// Program engine
	// ----------------------------------------------------------------
	osc_tick_div #(
		.DIV(OSC_TICK_CYCLES)
	) u_osc (
		.pclk(pclk),
		.rst_n(por_n),
		.run(program_go_bit),
		.tick(osc_tick)
	);

	// The engine ignores presetn so that a CPU reset cannot cut a cell write short.
	always_ff @(posedge pclk or negedge por_n) begin
		if (!por_n) begin
			state <= DEV_IDLE;
			ticks_left <= '0;
			op_addr <= '0;
			op_data <= '0;
			op_mode <= MODE_ATOMIC;
		end else begin
			case (state)
				DEV_IDLE: begin
					if (go_ok) begin
						state <= DEV_PROG;
						ticks_left <= prog_ticks(program_mode_select);
						op_addr <= nvm_byte_address_reg;
						op_data <= nvm_byte_data_reg;
						op_mode <= program_mode_select;
					end
				end
				DEV_PROG: begin
					if (commit) begin
						state <= DEV_IDLE;
					end else if (osc_tick) begin
						ticks_left <= ticks_left - ONE_TICK;
					end
				end
				default: state <= DEV_IDLE;
			endcase
		end
	end

	always_ff @(posedge pclk) begin
		if (commit) begin
			mem[op_addr] <= new_byte(op_mode, mem[op_addr], op_data);
		end
	end

	always_ff @(posedge pclk or negedge por_n) begin
		if (!por_n) begin
			program_mode_select <= MODE_ATOMIC;
		end else if (rst_seen && !program_go_bit) begin
			program_mode_select <= MODE_ATOMIC;
		end else if (wr_ctrl && !program_go_bit) begin
			program_mode_select <= bus.reg_wdata[CTRL_MODE +: 2];
		end
	end

	// ----------------------------------------------------------------
	// CPU-facing registers
	// ----------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			program_arm_bit <= 1'b0;
			arm_age <= 3'h0;
		end else if (go_ok) begin
			program_arm_bit <= 1'b0;
		end else if (wr_ctrl && bus.reg_wdata[CTRL_ARM]) begin
			program_arm_bit <= 1'b1;
			arm_age <= 3'h0;
		end else if (program_arm_bit) begin
			if (arm_age == ARM_WINDOW - 3'h1) begin
				program_arm_bit <= 1'b0;
			end else begin
				arm_age <= arm_age + 3'h1;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			stall_cnt <= 3'h0;
		end else if (read_ok) begin
			stall_cnt <= READ_STALL;
		end else if (go_ok) begin
			stall_cnt <= PROG_STALL;
		end else if (stall_cnt != 3'h0) begin
			stall_cnt <= stall_cnt - 3'h1;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			nvm_byte_address_reg <= '0;
			nvm_byte_data_reg <= '0;
		end else begin
			if (bus.reg_wr && bus.reg_sel == SEL_ADDR) begin
				nvm_byte_address_reg <= bus.reg_wdata[ADDR_W-1:0];
			end
			if (read_ok) begin
				nvm_byte_data_reg <= mem[nvm_byte_address_reg];
			end else if (bus.reg_wr && bus.reg_sel == SEL_DATA) begin
				nvm_byte_data_reg <= bus.reg_wdata;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			bus.reg_rdata <= '0;
		end else if (bus.reg_rd) begin
			case (bus.reg_sel)
				SEL_ADDR: bus.reg_rdata <= DATA_W'(nvm_byte_address_reg);
				SEL_DATA: bus.reg_rdata <= nvm_byte_data_reg;
				SEL_CTRL: begin
					bus.reg_rdata <= '0;
					bus.reg_rdata[CTRL_MODE +: 2] <= program_mode_select;
					bus.reg_rdata[CTRL_ARM] <= program_arm_bit;
					bus.reg_rdata[CTRL_GO] <= program_go_bit;
				end
				default: bus.reg_rdata <= '0;
			endcase
		end
	end
endmodule

// file: rtl/nvm_host_ctrl.sv
// Purpose: CPU-side end: APB registers that drive the EEPROM device port.
// Assumes: One APB master; pready follows the device stall.
// Notes: The command register issues arm and go back to back, so the window is never missed.
`timescale 1ns/1ps
module nvm_host_ctrl (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [nvm_pkg::APB_AW-1:0] paddr,
	input wire logic [nvm_pkg::APB_DW-1:0] pwdata,
	output logic [nvm_pkg::APB_DW-1:0] prdata,
	output logic pready,
	output logic pslverr,
	output logic irq,
	nvm_if.controller bus
);
	import nvm_pkg::*;

	host_state_t state;
	logic done;
	logic is_start;
	logic [1:0] cmd_mode;
	logic [ADDR_W-1:0] addr_shadow;
	logic [MEM_DEPTH-1:0] erased;
	logic [ST_W-1:0] status;
	logic [ST_W-1:0] mask;
	logic busy_q;
	logic refuse_evt;
	logic req;

	function automatic logic [1:0] dev_sel(input logic [APB_AW-1:0] a);
		case (a)
			OFF_ADDR: dev_sel = SEL_ADDR;
			OFF_DATA: dev_sel = SEL_DATA;
			default: dev_sel = SEL_CTRL;
		endcase
	endfunction

	function automatic logic [DATA_W-1:0] ctrl_word(input logic [1:0] mode, input int bitpos);
		ctrl_word = '0;
		ctrl_word[CTRL_MODE +: 2] = mode;
		ctrl_word[bitpos] = 1'b1;
	endfunction

	assign req = psel && penable && !done && (state == H_IDLE);
	assign pready = done;
	assign pslverr = 1'b0;
	assign irq = |(status & mask);

	// ----------------------------------------------------------------
	// Request sequencer
	// ----------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state <= H_IDLE;
			done <= 1'b0;
			prdata <= '0;
			is_start <= 1'b0;
			cmd_mode <= MODE_ATOMIC;
			addr_shadow <= '0;
			erased <= '0;
			mask <= '0;
			refuse_evt <= 1'b0;
			bus.reg_sel <= SEL_ADDR;
			bus.reg_wr <= 1'b0;
			bus.reg_rd <= 1'b0;
			bus.reg_wdata <= '0;
		end else begin
			done <= 1'b0;
			refuse_evt <= 1'b0;
			bus.reg_wr <= 1'b0;
			bus.reg_rd <= 1'b0;
			case (state)
				H_IDLE: begin
					if (req) begin
						prdata <= '0;
						is_start <= 1'b0;
						case (paddr)
							OFF_ADDR, OFF_DATA, OFF_CTRL: begin
								bus.reg_sel <= dev_sel(paddr);
								bus.reg_wr <= pwrite;
								bus.reg_rd <= !pwrite;
								bus.reg_wdata <= pwdata[DATA_W-1:0];
								if (pwrite && paddr == OFF_ADDR) begin
									addr_shadow <= pwdata[ADDR_W-1:0];
								end
								state <= H_WAIT;
							end
							OFF_CMD: begin
								if (pwrite && pwdata[CMD_START]) begin
									if (pwdata[CMD_MODE +: 2] == MODE_WRITE
										&& !erased[addr_shadow]) begin
										refuse_evt <= 1'b1;
										done <= 1'b1;
									end else begin
										cmd_mode <= pwdata[CMD_MODE +: 2];
										bus.reg_sel <= SEL_CTRL;
										bus.reg_wr <= 1'b1;
										bus.reg_wdata <= ctrl_word(pwdata[CMD_MODE +: 2], CTRL_ARM);
										is_start <= 1'b1;
										state <= H_GO;
									end
								end else if (pwrite && pwdata[CMD_READ]) begin
									bus.reg_sel <= SEL_CTRL;
									bus.reg_wr <= 1'b1;
									bus.reg_wdata <= ctrl_word(cmd_mode, CTRL_READ);
									state <= H_WAIT;
								end else begin
									done <= 1'b1;
								end
							end
							OFF_STATUS: begin
								prdata <= APB_DW'(status);
								done <= 1'b1;
							end
							OFF_MASK: begin
								if (pwrite) begin
									mask <= pwdata[ST_W-1:0];
								end
								prdata <= APB_DW'(mask);
								done <= 1'b1;
							end
							default: done <= 1'b1;
						endcase
					end
				end
				H_GO: begin
					// Go follows arm on the next cycle: no interrupt can split them.
					bus.reg_sel <= SEL_CTRL;
					bus.reg_wr <= 1'b1;
					bus.reg_wdata <= ctrl_word(cmd_mode, CTRL_GO);
					state <= H_WAIT;
				end
				H_WAIT: begin
					// The device answers an access one edge late, so the cycle in
					// which our own strobe still stands shows stale stall, busy and data.
					if (!bus.stall && !bus.reg_wr && !bus.reg_rd) begin
						prdata <= APB_DW'(bus.reg_rdata);
						done <= 1'b1;
						state <= H_IDLE;
						if (is_start && bus.busy) begin
							erased[addr_shadow] <= (cmd_mode == MODE_ERASE);
						end else if (is_start) begin
							refuse_evt <= 1'b1;
						end
					end
				end
				default: state <= H_IDLE;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Sticky status, write one to clear; a new event wins over the clear
	// ----------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			busy_q <= 1'b0;
			status <= '0;
		end else begin
			busy_q <= bus.busy;
			if (busy_q && !bus.busy) begin
				status[ST_DONE] <= 1'b1;
			end else if (req && pwrite && paddr == OFF_STATUS && pwdata[ST_DONE]) begin
				status[ST_DONE] <= 1'b0;
			end
			if (refuse_evt) begin
				status[ST_REFUSED] <= 1'b1;
			end else if (req && pwrite && paddr == OFF_STATUS && pwdata[ST_REFUSED]) begin
				status[ST_REFUSED] <= 1'b0;
			end
		end
	end
endmodule

// file: testbench/nvm_port_props.sv
// Purpose: Checks the device register port between the controller and the EEPROM device.
// Assumes: One pclk domain; presetn low disables every check.
// Notes: Busy length is checked against the shortened program counts given as parameters.
`timescale 1ns/1ps
module nvm_port_props #(
	parameter int ATOMIC_CYC = 340,
	parameter int SPLIT_CYC = 180
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [1:0] reg_sel,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [nvm_pkg::DATA_W-1:0] reg_wdata,
	input wire logic [nvm_pkg::DATA_W-1:0] reg_rdata,
	input wire logic stall,
	input wire logic busy
);
	import nvm_pkg::*;
	logic [2:0] arm_cnt;
	logic [1:0] arm_mode;
	logic [1:0] op_mode;
	logic [15:0] busy_len;
	logic ctrl_wr;
	logic go_ok;
	assign ctrl_wr = reg_wr && reg_sel == SEL_CTRL;
	assign go_ok = ctrl_wr && reg_wdata[CTRL_GO] && !busy && arm_cnt != 3'h0
		&& arm_mode != MODE_RSVD;
	// An arm stays good for four edges; a refused go does not consume it.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			arm_cnt <= 3'h0;
			arm_mode <= MODE_ATOMIC;
		end else if (ctrl_wr && reg_wdata[CTRL_ARM] && !busy) begin
			arm_cnt <= ARM_WINDOW;
			arm_mode <= reg_wdata[CTRL_MODE+:2];
		end else if (go_ok) begin
			arm_cnt <= 3'h0;
		end else if (arm_cnt != 3'h0) begin
			arm_cnt <= arm_cnt - 3'h1;
		end
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			op_mode <= MODE_ATOMIC;
			busy_len <= 16'h0;
		end else begin
			if (go_ok) begin
				op_mode <= arm_mode;
			end
			busy_len <= busy ? busy_len + 16'h1 : 16'h0;
		end
	end
	// ----------------------------------------------------------------
	// Properties
	// ----------------------------------------------------------------
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	sequence s_read_stall;
		stall [*4] ##1 !stall;
	endsequence
	sequence s_prog_stall;
		stall [*2] ##1 !stall;
	endsequence
	AST_READ_STALL: assert property (ctrl_wr && reg_wdata[CTRL_READ] && !reg_wdata[CTRL_GO]
		&& !busy |=> s_read_stall)
		else $error("read strobe stall is not four cycles");
	AST_PROG_STALL: assert property (go_ok |=> s_prog_stall)
		else $error("program start stall is not two cycles");
	AST_GO_BUSY: assert property (go_ok |=> busy)
		else $error("armed go did not start programming");
	AST_GO_REFUSED: assert property (ctrl_wr && reg_wdata[CTRL_GO] && !busy
		&& arm_cnt == 3'h0 |=> !busy && !stall)
		else $error("unarmed go started programming");
	AST_BUSY_READ: assert property (busy && ctrl_wr && reg_wdata[CTRL_READ]
		|=> !stall && $stable(reg_rdata))
		else $error("read strobe acted during programming");
	AST_BUSY_GO: assert property (busy && ctrl_wr && reg_wdata[CTRL_GO] |=> !stall)
		else $error("go acted during programming");
	AST_BUSY_TIME: assert property ($fell(busy) |-> (op_mode == MODE_ATOMIC)
		? (busy_len == ATOMIC_CYC || busy_len == ATOMIC_CYC + 1)
		: (busy_len == SPLIT_CYC || busy_len == SPLIT_CYC + 1))
		else $error("program time is wrong for the mode");
	AST_RDATA_HOLD: assert property (!reg_rd |=> $stable(reg_rdata))
		else $error("read data changed without a read");
	AST_NO_ACCESS_STALL: assert property (stall |-> !reg_wr && !reg_rd)
		else $error("access issued while stalled");
endmodule

// file: testbench/tb_top.sv
// Purpose: Self-checking bench for the APB controller joined to the EEPROM device.
// Assumes: pclk 200 MHz; program counts shortened by device parameters.
// Notes: Memory content is unknown after power-up, so every read follows a program.
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin n_compared++; if ((got) !== (exp)) begin error_cnt++; \
	$display("[FAIL] %s exp %0h got %0h", nm, exp, got); end end
module tb_top;
	import nvm_pkg::*;
	localparam int TICK_CYC = 10;
	localparam int AT_US = 34;
	localparam int SP_US = 18;
	localparam int TPU = NS_PER_US / OSC_TICK_NS;
	localparam int AT_CYC = AT_US * TPU * TICK_CYC;
	localparam int SP_CYC = SP_US * TPU * TICK_CYC;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic por_n = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [APB_AW-1:0] paddr = '0;
	logic [APB_DW-1:0] pwdata = '0;
	logic [APB_DW-1:0] prdata;
	logic pready;
	logic pslverr;
	logic irq;
	int error_cnt = 0;
	int n_compared = 0;
	nvm_if i_nvm_if();
	nvm_byte_device #(.PROG_ATOMIC_US(AT_US), .PROG_SPLIT_US(SP_US), .OSC_TICK_CYCLES(TICK_CYC))
		i_nvm_byte_device (.pclk(pclk), .presetn(presetn), .por_n(por_n), .bus(i_nvm_if));
	nvm_host_ctrl i_nvm_host_ctrl (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .irq(irq), .bus(i_nvm_if));
	nvm_port_props #(.ATOMIC_CYC(AT_CYC), .SPLIT_CYC(SP_CYC)) i_nvm_port_props (.pclk(pclk),
		.presetn(presetn), .reg_sel(i_nvm_if.reg_sel), .reg_wr(i_nvm_if.reg_wr),
		.reg_rd(i_nvm_if.reg_rd), .reg_wdata(i_nvm_if.reg_wdata),
		.reg_rdata(i_nvm_if.reg_rdata), .stall(i_nvm_if.stall), .busy(i_nvm_if.busy));
	always #2.5 pclk = ~pclk;
	// ----------------------------------------------------------------
	// Bus tasks
	// ----------------------------------------------------------------
	task automatic apb(input logic w, input logic [APB_AW-1:0] a, input logic [APB_DW-1:0] d,
		output logic [APB_DW-1:0] v);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1)
			@(posedge pclk);
		v = prdata;
		`CHK("pslverr", 1'b0, pslverr)
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wr(input logic [APB_AW-1:0] a, input logic [APB_DW-1:0] d);
		logic [APB_DW-1:0] v;
		apb(1'b1, a, d, v);
	endtask
	task automatic rd(input logic [APB_AW-1:0] a, output logic [APB_DW-1:0] v);
		apb(1'b0, a, '0, v);
	endtask
	task automatic prog(input logic [1:0] m, input logic [5:0] a, input logic [7:0] d);
		wr(OFF_ADDR, {26'h0, a});
		wr(OFF_DATA, {24'h0, d});
		wr(OFF_CMD, {26'h0, m, 4'h1});
	endtask
	task automatic get(input logic [5:0] a, input logic [7:0] e);
		logic [APB_DW-1:0] v;
		wr(OFF_ADDR, {26'h0, a});
		wr(OFF_CMD, 32'h2);
		rd(OFF_DATA, v);
		`CHK("byte", e, v[7:0])
	endtask
	task automatic wait_done(input logic m);
		logic [APB_DW-1:0] v;
		v = '0;
		for (int i = 0; i < 400 && v[ST_DONE] !== 1'b1; i++) begin
			rd(OFF_STATUS, v);
		end
		`CHK("done", 1'b1, v[ST_DONE])
		`CHK("irq on", m, irq)
		wr(OFF_STATUS, 32'h3);
		@(negedge pclk);
		`CHK("irq off", 1'b0, irq)
	endtask
	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	task automatic t_reset();
		logic [APB_DW-1:0] v;
		rd(OFF_CTRL, v);
		`CHK("ctrl reset", 32'h0, v)
		rd(OFF_STATUS, v);
		`CHK("status reset", 32'h0, v)
		rd(12'h020, v);
		`CHK("unmapped", 32'h0, v)
	endtask
	task automatic t_modes();
		logic [1:0] md [3] = '{MODE_ATOMIC, MODE_ERASE, MODE_WRITE};
		logic [7:0] dt [3] = '{8'h5a, 8'h00, 8'h3c};
		logic [7:0] ex [3] = '{8'h5a, 8'hff, 8'h3c};
		logic [APB_DW-1:0] v;
		for (int i = 0; i < 3; i++) begin
			wr(OFF_MASK, {31'h0, i == 0});
			prog(md[i], 6'h3f, dt[i]);
			rd(OFF_CTRL, v);
			`CHK("ctrl busy", {2'b0, md[i], 4'h2}, v[7:0])
			wait_done(i == 0);
			get(6'h3f, ex[i]);
		end
	endtask
	task automatic t_busy();
		logic [APB_DW-1:0] v;
		prog(MODE_ATOMIC, 6'h00, 8'ha5);
		wr(OFF_CTRL, 32'h33);
		rd(OFF_CTRL, v);
		`CHK("mode kept", 8'h02, v[7:0])
		wr(OFF_ADDR, 32'h1);
		wait_done(1'b0);
		get(6'h00, 8'ha5);
		get(6'h3f, 8'h3c);
	endtask
	task automatic t_refuse();
		logic [APB_DW-1:0] v;
		wr(OFF_DATA, 32'h11);
		wr(OFF_CTRL, 32'h02);
		rd(OFF_CTRL, v);
		`CHK("unarmed go", 8'h00, v[7:0])
		wr(OFF_CTRL, 32'h04);
		repeat (10) @(posedge pclk);
		wr(OFF_CTRL, 32'h02);
		rd(OFF_CTRL, v);
		`CHK("expired arm", 8'h00, v[7:0])
		get(6'h3f, 8'h3c);
		prog(MODE_WRITE, 6'h00, 8'h0f);
		rd(OFF_STATUS, v);
		`CHK("unerased write", 32'h2, v)
		wr(OFF_STATUS, 32'h3);
		prog(MODE_RSVD, 6'h00, 8'h0f);
		rd(OFF_STATUS, v);
		`CHK("reserved mode", 32'h2, v)
		wr(OFF_STATUS, 32'h3);
		get(6'h00, 8'ha5);
	endtask
	task automatic t_mode_reset();
		logic [APB_DW-1:0] v;
		wr(OFF_CTRL, 32'h20);
		rd(OFF_CTRL, v);
		`CHK("mode set", 8'h20, v[7:0])
		presetn <= 1'b0;
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		repeat (4) @(posedge pclk);
		rd(OFF_CTRL, v);
		`CHK("mode cleared", 8'h00, v[7:0])
	endtask
	task automatic final_report();
		$display("compared %0d mismatches %0d", n_compared, error_cnt);
		if (error_cnt == 0 && n_compared > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	// The whole sequence needs some 1500 cycles; the limit leaves ample margin.
	initial begin
		repeat (20000) @(posedge pclk);
		error_cnt++;
		final_report();
	end
	initial begin
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		por_n <= 1'b1;
		t_reset();
		t_modes();
		t_busy();
		t_refuse();
		t_mode_reset();
		final_report();
	end
endmodule
